// File: lksc_pkg.sv
package lksc_pkg;
    // Oscillator period in pclk cycles; 50 MHz / 800 = 62.5 kHz
    localparam int OSC_DIV = 800;
    localparam int FRAME_OSC = 24;
    localparam int SCAN_OSC = 20;
    localparam int ROW_OSC = 4;
    localparam int COM4_OSC = 6;
    localparam int COM3_OSC = 8;
    localparam int KEY_BITS = 30;
    localparam int SEG_N = 29;
    localparam int SR_W = 36;
    localparam int ROWS = 5;
    localparam int COLS = 6;
    localparam int COMS = 4;
    // Shift register positions: the top command bit lands at bit 0
    localparam int SR_OP_LO = 0;
    localparam int SR_DISP_BIT = 3;
    localparam int SR_ROW_LO = 4;
    localparam int SR_SEG_LO = 6;
    localparam int SR_LED = 35;
    localparam logic [2:0] OP_ROW = 3'h1;
    localparam logic [2:0] OP_KEY = 3'h2;
    localparam logic [2:0] OP_ROWKEY = 3'h3;
    localparam logic [2:0] OP_HALT = 3'h4;
    localparam logic [2:0] OP_DISP = 3'h5;
    localparam logic [2:0] OP_HALTKEY = 3'h6;
    localparam logic [2:0] OP_BEGIN = 3'h7;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STATUS = 12'h004;
    localparam logic [11:0] A_KEYS = 12'h008;
    localparam logic [11:0] A_LED = 12'h00C;
    localparam logic [11:0] A_ROW0 = 12'h010;
    localparam logic [11:0] A_ROW3 = 12'h01C;
    localparam logic [31:0] CTRL_RST = 32'h0;
    typedef enum logic [1:0] {LK_IDLE, LK_ARMED, LK_OUT} lksc_link_t;
endpackage

// File: lksc_scan_if.sv
`timescale 1ns/100ps
interface lksc_scan_if;
    import lksc_pkg::*;
    logic osc_tick;
    logic begin_scan;
    logic halt_scan;
    logic scanning;
    logic scan_done;
    logic [COLS-1:0] cols;
    logic [ROWS-1:0] rows;
    logic [KEY_BITS-1:0] keys;
    modport ctl(output osc_tick, begin_scan, halt_scan, cols,
        input scanning, scan_done, rows, keys);
    modport scn(input osc_tick, begin_scan, halt_scan, cols,
        output scanning, scan_done, rows, keys);
endinterface

// File: lksc_scan.sv
`timescale 1ns/100ps
module lksc_scan
    import lksc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    lksc_scan_if.scn sif
);
    logic [4:0] cnt_r;
    logic on_r;
    logic [KEY_BITS-1:0] keys_r;
    logic [ROWS-1:0] rows_r;
    wire [2:0] row_idx = 3'(cnt_r / 5'(ROW_OSC));
    wire [4:0] key_base = 5'(row_idx) * 5'h6;
    wire row_end = (cnt_r % 5'(ROW_OSC)) == 5'(ROW_OSC - 1);
    wire cyc_end = cnt_r == 5'(SCAN_OSC - 1);
    wire [ROWS-1:0] rows_nxt = on_r ? ~(5'h1 << row_idx) : 5'h0;

    assign sif.scanning = on_r;
    assign sif.rows = rows_r;
    assign sif.keys = keys_r;
    // A halt in the same cycle wins, so the flag cannot rise after a stop
    assign sif.scan_done = on_r & sif.osc_tick & cyc_end & ~sif.halt_scan;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 5'h0;
            on_r <= 1'b0;
            keys_r <= '0;
            rows_r <= '0;
        end else begin
            rows_r <= rows_nxt;
            if (sif.halt_scan) begin
                on_r <= 1'b0;
                cnt_r <= 5'h0;
            end else if (sif.begin_scan && !on_r) begin
                on_r <= 1'b1;
                cnt_r <= 5'h0;
            end else if (on_r && sif.osc_tick) begin
                // Sample late in each row slot so the column has settled
                if (row_end) begin
                    keys_r[key_base +: COLS] <= ~sif.cols;
                end
                cnt_r <= cyc_end ? 5'h0 : cnt_r + 5'h1;
            end
        end
    end
endmodule

// File: lksc_top.sv
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module lksc_sync #(parameter int W = 1) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            q <= '0;
        end else begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule

module lksc_top
    import lksc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_clock,
    input wire logic load_pulse,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    input wire logic [COLS-1:0] key_column_sense,
    output logic [ROWS-1:0] key_row_drive,
    output logic scan_done_flag,
    output logic [SEG_N-1:0] segment_outputs,
    output logic [COMS-1:0] common_row_outputs,
    output logic led_output
);
    // ******************************************
    // Pin synchronisers
    // ******************************************
    logic [2:0] pins_s;
    logic [COLS-1:0] cols_n_s;
    logic sclk_d_r;
    logic load_d_r;
    logic [COLS-1:0] cols_d_r;

    lksc_sync #(.W(3)) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({serial_clock, load_pulse, serial_data_in}),
        .q(pins_s)
    );
    lksc_sync #(.W(COLS)) u_col_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(~key_column_sense),
        .q(cols_n_s)
    );

    wire sclk_s = pins_s[2];
    wire load_s = pins_s[1];
    wire din_s = pins_s[0];
    // Columns pass inverted so the flops reset to the pulled-up idle level
    wire [COLS-1:0] cols_s = ~cols_n_s;
    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire load_rise = load_s & ~load_d_r;

    // ******************************************
    // Oscillator and frame timing
    // ******************************************
    logic [9:0] osc_cnt_r;
    logic [4:0] frm_cnt_r;
    wire osc_tick = osc_cnt_r == 10'(OSC_DIV - 1);

    // ******************************************
    // Scanner
    // ******************************************
    lksc_scan_if sif ();
    lksc_scan u_scan (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif.scn)
    );

    // ******************************************
    // Serial link and command decode
    // ******************************************
    logic [SR_W-1:0] sr_r;
    lksc_link_t link_st_r;
    lksc_link_t link_st_nxt;
    logic [4:0] out_idx_r;
    logic data_out_r;
    logic oe_n_r;
    logic disp_on_r;
    logic led_bit_r;
    logic int_r;
    logic [SEG_N-1:0] latch_r [COMS];
    logic duty3_r;

    function automatic logic op_readout(input logic [2:0] op);
        op_readout = op == OP_KEY || op == OP_ROWKEY ||
            op == OP_HALTKEY || op == OP_BEGIN;
    endfunction

    function automatic logic op_halts(input logic [2:0] op);
        op_halts = op == OP_HALT || op == OP_HALTKEY;
    endfunction

    function automatic logic op_rowwrite(input logic [2:0] op);
        op_rowwrite = op == OP_ROW || op == OP_ROWKEY;
    endfunction

    // Top command bit is the last one shifted, so short frames still decode
    wire [2:0] op_w = {sr_r[SR_OP_LO], sr_r[SR_OP_LO+1], sr_r[SR_OP_LO+2]};
    wire [1:0] row_w = {sr_r[SR_ROW_LO], sr_r[SR_ROW_LO+1]};
    wire [SEG_N-1:0] seg_w = sr_r[SR_SEG_LO +: SEG_N];
    wire commit = load_rise && link_st_r == LK_IDLE;
    wire release_ld = load_rise && link_st_r != LK_IDLE;
    wire do_row = commit && op_rowwrite(op_w);
    wire do_arm = commit && op_readout(op_w);
    wire do_halt = commit && op_halts(op_w);
    wire do_begin = commit && op_w == OP_BEGIN;
    wire do_disp = commit && op_w == OP_DISP;
    wire col_change = cols_s != cols_d_r;
    wire int_clr = do_halt || (release_ld && link_st_r == LK_OUT);
    wire int_nxt = sif.scan_done | (int_r & ~int_clr);
    wire [4:0] idx_nxt = out_idx_r == 5'(KEY_BITS - 1) ? 5'h0 : out_idx_r + 5'h1;

    assign sif.osc_tick = osc_tick;
    assign sif.cols = cols_s;
    assign sif.halt_scan = do_halt;
    // All rows sit low when idle, so any press shows as a column change
    assign sif.begin_scan = do_begin || (!sif.scanning && col_change);

    always_comb begin
        link_st_nxt = link_st_r;
        case (link_st_r)
            LK_IDLE: begin
                if (do_arm) begin
                    link_st_nxt = LK_ARMED;
                end
            end
            LK_ARMED: begin
                if (release_ld) begin
                    link_st_nxt = LK_IDLE;
                end else if (sclk_rise) begin
                    link_st_nxt = LK_OUT;
                end
            end
            LK_OUT: begin
                if (release_ld) begin
                    link_st_nxt = LK_IDLE;
                end
            end
            default: link_st_nxt = LK_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d_r <= 1'b0;
            load_d_r <= 1'b0;
            cols_d_r <= '1;
            link_st_r <= LK_IDLE;
            int_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            load_d_r <= load_s;
            cols_d_r <= cols_s;
            link_st_r <= link_st_nxt;
            int_r <= int_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_r <= '0;
        end else if (sclk_rise && link_st_r == LK_IDLE) begin
            sr_r <= {sr_r[SR_W-2:0], din_s};
        end
    end

    // Key bits leave on each clock rise and wrap after the thirtieth
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_idx_r <= 5'h0;
            data_out_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else if (release_ld) begin
            out_idx_r <= 5'h0;
            oe_n_r <= 1'b1;
        end else if (sclk_rise && link_st_r != LK_IDLE) begin
            data_out_r <= sif.keys[out_idx_r];
            out_idx_r <= idx_nxt;
            oe_n_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_on_r <= 1'b0;
            led_bit_r <= 1'b0;
            for (int i = 0; i < COMS; i++) begin
                latch_r[i] <= '0;
            end
        end else begin
            if (do_disp) begin
                disp_on_r <= sr_r[SR_DISP_BIT];
            end
            if (do_row) begin
                latch_r[row_w] <= seg_w;
                if (row_w == 2'h0) begin
                    led_bit_r <= sr_r[SR_LED];
                end
            end
        end
    end

    // ******************************************
    // Display drive
    // ******************************************
    wire [4:0] com_len = duty3_r ? 5'(COM3_OSC) : 5'(COM4_OSC);
    wire [1:0] com_idx = 2'(frm_cnt_r / com_len);
    wire frm_end = frm_cnt_r == 5'(FRAME_OSC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_r <= '0;
            frm_cnt_r <= '0;
            segment_outputs <= '0;
            common_row_outputs <= '0;
            led_output <= 1'b0;
        end else begin
            osc_cnt_r <= osc_tick ? 10'h0 : osc_cnt_r + 10'h1;
            if (osc_tick) begin
                frm_cnt_r <= frm_end ? 5'h0 : frm_cnt_r + 5'h1;
            end
            common_row_outputs <= 4'h1 << com_idx;
            // Blanking gates outputs only; latches keep their contents
            segment_outputs <= disp_on_r ? latch_r[com_idx] : '0;
            led_output <= disp_on_r & led_bit_r;
        end
    end

    assign key_row_drive = sif.rows;
    assign scan_done_flag = int_r;
    assign serial_data_out = data_out_r;
    assign serial_data_oe_n = oe_n_r;

    // ******************************************
    // APB slave
    // ******************************************
    wire setup = psel && !penable;
    wire wr_ctrl = psel && penable && pwrite && paddr == A_CTRL;
    wire row_hit = paddr >= A_ROW0 && paddr <= A_ROW3 && paddr[1:0] == 2'h0;
    wire mapped = paddr == A_CTRL || paddr == A_STATUS || paddr == A_KEYS ||
        paddr == A_LED || row_hit;
    wire [1:0] rd_row = 2'(paddr[3:2]);
    logic [31:0] rd_w;

    always_comb begin
        rd_w = 32'h0;
        case (paddr)
            A_CTRL: rd_w = {31'h0, duty3_r};
            A_STATUS: rd_w = {27'h0, link_st_r, int_r,
                sif.scanning, disp_on_r};
            A_KEYS: rd_w = {2'h0, sif.keys};
            A_LED: rd_w = {31'h0, led_bit_r};
            default: rd_w = row_hit ? {3'h0, latch_r[rd_row]} : 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
            duty3_r <= CTRL_RST[0];
        end else begin
            if (setup) begin
                prdata <= pwrite ? 32'h0 : rd_w;
                pslverr <= !mapped;
            end
            if (wr_ctrl) begin
                duty3_r <= pwdata[0];
            end
        end
    end

    assign pready = 1'b1;

    // ******************************************
    // Checks
    // ******************************************
    logic [5:0] tick_cnt_r;
    logic seen_done_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= '0;
            seen_done_r <= 1'b0;
        end else if (sif.scan_done || !sif.scanning) begin
            tick_cnt_r <= '0;
            seen_done_r <= sif.scan_done;
        end else if (osc_tick) begin
            tick_cnt_r <= tick_cnt_r + 6'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_off_cmd;
        do_disp && !sr_r[SR_DISP_BIT];
    endsequence
    sequence s_on_cmd;
        do_disp && sr_r[SR_DISP_BIT];
    endsequence

    property p_blank;
        !disp_on_r |=> segment_outputs == '0 && !led_output;
    endproperty
    a_blank: assert property (p_blank) else $error("outputs lit while blank");

    property p_off_keeps;
        s_off_cmd |=> !disp_on_r && $stable(latch_r[0]) ##1 segment_outputs == '0;
    endproperty
    a_off_keeps: assert property (p_off_keeps) else $error("display off failed");

    property p_on;
        s_on_cmd ##1 !do_row |=> segment_outputs == latch_r[$past(com_idx)];
    endproperty
    a_on: assert property (p_on) else $error("display on shows wrong data");

    property p_row;
        do_row |=> latch_r[$past(row_w)] == $past(seg_w);
    endproperty
    a_row: assert property (p_row) else $error("row latch not loaded");

    property p_arm;
        do_arm |=> link_st_r == LK_ARMED;
    endproperty
    a_arm: assert property (p_arm) else $error("readout not armed");

    property p_halt;
        do_halt |=> !sif.scanning && !int_r ##1 key_row_drive == '0;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not obeyed");

    property p_begin;
        do_begin |=> sif.scanning;
    endproperty
    a_begin: assert property (p_begin) else $error("scan did not start");

    property p_led;
        do_row && row_w != 2'h0 |=> $stable(led_bit_r);
    endproperty
    a_led: assert property (p_led) else $error("LED taken from other row");

    property p_scan_len;
        sif.scan_done && seen_done_r |-> tick_cnt_r == 6'(SCAN_OSC - 1);
    endproperty
    a_scan_len: assert property (p_scan_len) else $error("scan cycle length");

    property p_out_bit;
        sclk_rise && link_st_r != LK_IDLE && !load_rise |=>
            !serial_data_oe_n && serial_data_out == $past(sif.keys[out_idx_r]);
    endproperty
    a_out_bit: assert property (p_out_bit) else $error("key bit not driven");

    property p_int;
        sif.scan_done |=> scan_done_flag;
    endproperty
    a_int: assert property (p_int) else $error("scan flag not set");

    property p_col_start;
        !sif.scanning && col_change && !do_halt |=> sif.scanning;
    endproperty
    a_col_start: assert property (p_col_start) else $error("no scan on change");

    property p_one_row;
        sif.scanning |=> $countones(~key_row_drive) <= 1;
    endproperty
    a_one_row: assert property (p_one_row) else $error("multiple rows driven");
endmodule

// File: lksc_host.sv
`timescale 1ns/100ps
// ****************************************
// Host side of the serial link
// ****************************************
module lksc_host (
    input wire logic pclk,
    input wire logic sd_wire,
    output logic sclk,
    output logic load,
    output logic hd,
    output logic hdrv
);
    initial begin
        sclk = 1'b0;
        load = 1'b0;
        hd = 1'b0;
        hdrv = 1'b1;
    end

    // Half of a 160 ns link period
    task automatic half();
        repeat (4) @(posedge pclk);
    endtask

    // Filler and an unused LED bit are simply left off the front of the stream
    task automatic shift(input logic [35:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            hd <= v[i];
            half();
            sclk <= 1'b1;
            half();
            sclk <= 1'b0;
        end
        half();
    endtask

    task automatic pulse();
        load <= 1'b1;
        half();
        load <= 1'b0;
        half();
    endtask

    // Sampled late in the period, well after the device has updated the line
    task automatic rd(output logic b);
        hdrv <= 1'b0;
        sclk <= 1'b1;
        half();
        sclk <= 1'b0;
        repeat (3) @(posedge pclk);
        b = sd_wire;
        @(posedge pclk);
    endtask

    // The line is unsettled just after the release load, so drive again later
    task automatic release_link();
        pulse();
        half();
        hdrv <= 1'b1;
    endtask
endmodule

// File: tb.sv
`timescale 1ns/100ps
module tb;
    import lksc_pkg::*;
    localparam logic [28:0] S0 = 29'h1234_5678;
    localparam logic [28:0] S2 = 29'h0ABC_DEF0;
    localparam logic [29:0] KEYS = 30'h2000_0002;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic sclk, load, hd, hdrv, sd_last, sd_wire;
    logic serial_data_out, serial_data_oe_n, scan_done_flag, led_output;
    logic [COLS-1:0] key_column_sense;
    logic [ROWS-1:0] key_row_drive;
    logic [SEG_N-1:0] segment_outputs;
    logic [COMS-1:0] common_row_outputs;
    logic [KEY_BITS-1:0] pressed;
    int errors, compares;

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    // Undriven line shows the inverse of its last level instead of a kind guess
    assign sd_wire = !serial_data_oe_n ? serial_data_out : (hdrv ? hd : ~sd_last);
    always @(posedge pclk) sd_last <= sd_wire;

    // Closed key pulls its column low only while its row is driven low
    always_comb begin
        key_column_sense = '1;
        for (int i = 0; i < KEY_BITS; i++) begin
            if (pressed[i] && !key_row_drive[i / COLS])
                key_column_sense[i % COLS] = 1'b0;
        end
    end

    lksc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_clock(sclk), .load_pulse(load),
        .serial_data_in(sd_wire), .serial_data_out(serial_data_out),
        .serial_data_oe_n(serial_data_oe_n), .key_column_sense(key_column_sense),
        .key_row_drive(key_row_drive), .scan_done_flag(scan_done_flag),
        .segment_outputs(segment_outputs), .common_row_outputs(common_row_outputs),
        .led_output(led_output));

    lksc_host host (.pclk(pclk), .sd_wire(sd_wire), .sclk(sclk), .load(load), .hd(hd),
        .hdrv(hdrv));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let an edge pass so a following call never reassigns psel in this step
        @(posedge pclk);
    endtask

    task automatic rreg(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        chk(d, exp);
    endtask

    // Stream order: LED bit, segments 28..0, then command bits C0..C5 so C5 goes last
    function automatic logic [35:0] frame(input logic led, input logic [28:0] s,
        input logic [5:0] c);
        logic [35:0] v;
        v[35] = led;
        for (int k = 0; k < 29; k++)
            v[SR_SEG_LO + k] = s[k];
        for (int j = 0; j < 6; j++)
            v[5 - j] = c[j];
        return v;
    endfunction

    task automatic cmd(input logic [5:0] c, input int n);
        host.shift(frame(1'b0, 29'h0, c), n);
        host.pulse();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset();
        logic [31:0] d;
        logic e;
        chk({scan_done_flag, led_output, serial_data_oe_n}, 32'h1);
        chk(32'(key_row_drive), 32'h0);
        chk(32'(segment_outputs), 32'h0);
        rreg(A_STATUS, 32'h0);
        apb(1'b0, 12'hFF0, 32'h0, d, e);
        chk(32'(e), 32'h1);
        $display("test_reset done");
    endtask

    task automatic test_display();
        int n;
        logic [31:0] d;
        logic e;
        host.shift(frame(1'b1, S0, {OP_ROW, 3'h0}), 36);
        host.pulse();
        chk({led_output, segment_outputs}, 32'h0);
        rreg(A_ROW0, 32'(S0));
        rreg(A_LED, 32'h1);
        host.shift(frame(1'b0, S2, {OP_ROW, 3'h2}), 35);
        host.pulse();
        rreg(A_ROW0 + 12'h8, 32'(S2));
        rreg(A_LED, 32'h1);
        cmd({OP_DISP, 3'h4}, 4);
        chk(32'(led_output), 32'h1);
        rreg(A_STATUS, 32'h1);
        // Frame length must not depend on the duty setting
        apb(1'b1, A_CTRL, 32'h1, d, e);
        rreg(A_CTRL, 32'h1);
        n = 0;
        // Start the count at a fresh rise of the first common row
        while (common_row_outputs[0] === 1'b1 && n < 30000) begin
            @(posedge pclk);
            n++;
        end
        while (common_row_outputs[0] !== 1'b1 && n < 30000) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (common_row_outputs[0] === 1'b1 && n < 30000);
        do begin
            @(posedge pclk);
            n++;
        end while (common_row_outputs[0] !== 1'b1 && n < 30000);
        chk(32'(n), 32'(FRAME_OSC * OSC_DIV));
        @(posedge pclk);
        chk(32'(segment_outputs), 32'(S0));
        cmd({OP_DISP, 3'h0}, 4);
        chk({led_output, segment_outputs}, 32'h0);
        rreg(A_ROW0, 32'(S0));
        cmd({OP_DISP, 3'h4}, 4);
        chk(32'(led_output), 32'h1);
        $display("test_display done");
    endtask

    task automatic test_keys();
        int n;
        logic b;
        pressed <= KEYS;
        n = 0;
        while (scan_done_flag !== 1'b1 && n < 22 * OSC_DIV) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n >= 19 * OSC_DIV && n <= 21 * OSC_DIV + 20), 32'h1);
        chk(32'($countones(~key_row_drive)), 32'h1);
        host.shift(frame(1'b0, S2, {OP_ROWKEY, 3'h3}), 36);
        host.pulse();
        chk(32'(serial_data_oe_n), 32'h1);
        for (int i = 0; i < 32; i++) begin
            host.rd(b);
            chk(32'(b), 32'(KEYS[i % 30]));
        end
        chk(32'(serial_data_oe_n), 32'h0);
        host.release_link();
        chk({scan_done_flag, serial_data_oe_n}, 32'h1);
        rreg(A_ROW3, 32'(S2));
        n = 0;
        while (scan_done_flag !== 1'b1 && n < 21 * OSC_DIV) begin
            @(posedge pclk);
            n++;
        end
        // Scanning runs on, so the next cycle ends within one scan period
        chk(32'(n > 0 && n <= SCAN_OSC * OSC_DIV), 32'h1);
        $display("test_keys done");
    endtask

    task automatic test_cmds();
        logic [2:0] ops [3] = '{OP_KEY, OP_HALTKEY, OP_BEGIN};
        logic run [3] = '{1'b1, 1'b0, 1'b1};
        logic [31:0] d;
        logic e;
        logic b;
        // Keys released first so that halting cannot look like a column change
        pressed <= '0;
        repeat (2 * OSC_DIV) @(posedge pclk);
        foreach (ops[i]) begin
            cmd({ops[i], 3'h5}, 3);
            host.rd(b);
            chk(32'(serial_data_oe_n), 32'h0);
            host.release_link();
            chk(32'(serial_data_oe_n), 32'h1);
            apb(1'b0, A_STATUS, 32'h0, d, e);
            chk(32'(d[1]), 32'(run[i]));
        end
        cmd({OP_HALT, 3'h7}, 6);
        apb(1'b0, A_STATUS, 32'h0, d, e);
        chk({d[2:1], scan_done_flag}, 32'h0);
        chk(32'(key_row_drive), 32'h0);
        pressed <= 30'h0000_4000;
        repeat (3 * OSC_DIV) @(posedge pclk);
        apb(1'b0, A_STATUS, 32'h0, d, e);
        chk(32'(d[1]), 32'h1);
        pressed <= '0;
        $display("test_cmds done");
    endtask

    task automatic test_done();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #2_000_000;
        errors++;
        test_done();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pressed = '0;
        errors = 0;
        compares = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        test_reset();
        test_display();
        test_keys();
        test_cmds();
        test_done();
    end
endmodule
